// file: src/wcs_pkg.sv
/*
 * Shared types and constants of the weld counter and status output block.
 * Assumes a single 10 MHz system clock and a sequencer on that clock.
 */
package wcs_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ         = 10_000_000;
   localparam int CYC_PER_MS     = CLK_HZ / 1000;
   localparam int CLR_TIMEOUT_MS = 3000;
   localparam int DONE_MIN_MS    = 40;
   localparam int CLR_CYCLES     = CLR_TIMEOUT_MS * CYC_PER_MS;
   localparam int DONE_CYCLES    = DONE_MIN_MS * CYC_PER_MS;
   localparam int CLR_TMR_W      = 25;
   localparam int DONE_TMR_W     = 19;

   // ----------------------------------------------------------------
   // widths and reset values
   // ----------------------------------------------------------------
   localparam int COUNT_W = 17;
   localparam int PIN_W   = 5;
   localparam logic [COUNT_W-1:0] COUNT_RST = 17'h00000;

   // bit positions of the synchronised pin vector
   localparam int PIN_START = 0;
   localparam int PIN_CLEAR = 1;
   localparam int PIN_CONF  = 2;
   localparam int PIN_FCLR  = 3;
   localparam int PIN_RUN   = 4;

   // ----------------------------------------------------------------
   // modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {WM_PERCENT, WM_CONST_CURRENT, WM_CONST_ENERGY} wcs_work_mode_t;
   typedef enum logic [1:0] {LS_OFF, LS_CURRENT, LS_ANGLE, LS_BOTH} wcs_limit_sel_t;
   typedef enum logic [1:0] {QS_NONE, QS_THICKNESS, QS_INDENT} wcs_quality_sel_t;

   typedef struct packed {
      wcs_work_mode_t   work_mode;
      wcs_limit_sel_t   limit_sel;
      wcs_quality_sel_t quality_sel;
      logic             aux_input_select;   // 1: pressure sensor on aux input
      logic             dry_cycle;
      logic             cascade_en;
      logic             pause_en;
      logic             off_time_en;
      logic             stop_on_error;      // a bad weld also raises a displayed error
      logic [COUNT_W-1:0] weld_limit;
   } wcs_cfg_t;

   typedef struct packed {
      logic start_req;
      logic squeeze;
      logic hold_start;
      logic hold_end;
      logic pause_end;
      logic off_end;
      logic weld_done;
      logic current_active;
   } wcs_seq_t;

   typedef struct packed {
      logic valid;
      logic cur_lo;
      logic cur_hi;
      logic ang_lo;
      logic ang_hi;
      logic no_current;
      logic time_lo;
      logic time_hi;
      logic no_electrode_voltage;
      logic electrode_voltage_oos;
      logic thickness_check_lo;
      logic thickness_check_hi;
      logic indent_lo;
      logic indent_hi;
      logic press_out;
   } wcs_res_t;

endpackage

// file: src/wcs_sync.sv
/*
 * Two flip-flop synchroniser for a vector of independent pin levels.
 * Assumes each bit is a slow level; no bus coherence between bits.
 */
module wcs_sync #(
   parameter int W = 1
) (
   input  wire logic         i_mclk,
   input  wire logic         i_resetn,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } wcs_sync_st_t;

   wcs_sync_st_t st_q;
   wcs_sync_st_t st_d;

   always_comb
   begin
      st_d.s1 = i_async;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_sync = st_q.s2;

endmodule

// file: src/wcs_top.sv
/*
 * Weld counter and status outputs: weld counting, confirmed counter
 * clear, weld-limit stop, weld fault, cycle-done and current-on contacts.
 * Assumes the cycle sequencer and measurement unit run on i_mclk and
 * give one-cycle event pulses; panel keys and plant pins are asynchronous.
 */
// Functional notes
// - count each completed weld by one and show the count
// - dry-cycle welds are not counted
// - counter clear accepted in run configuration only
// - clear key asks, confirm zeroes, three seconds without confirm abandons
// - count at limit signals and inhibits welds until counter reset
// - a zero weld limit disables the limit stop
// - bad weld closes fault at hold start, holds to latest ending condition
// - displayed error keeps fault closed until clear key or fault-clear input
// - percentage mode faults only on selected limits, none when checks off
// - constant current adds missing current; checks off leaves only that
// - constant energy adds time, electrode voltage missing or out of scale
// - quality check faults on thickness or indentation outside limits
// - bad squeeze pressure then start removed raises fault and error
// - cycle-done closes at end of hold time
// - cycle-done held by start, 40 ms, off time, or displayed message
// - current-on closed through every current interval and ramp
// - cascade inverts the cycle-done contact
module wcs_top #(
   parameter int CLR_CYCLES  = wcs_pkg::CLR_CYCLES,
   parameter int DONE_CYCLES = wcs_pkg::DONE_CYCLES
) (
   input  wire logic                        i_mclk,
   input  wire logic                        i_resetn,
   input  wire logic                        i_start_pin,
   input  wire logic                        i_clear_key,
   input  wire logic                        i_confirm_key,
   input  wire logic                        i_fault_clear,
   input  wire logic                        i_run_sel,
   input  wire wcs_pkg::wcs_cfg_t           i_cfg,
   input  wire wcs_pkg::wcs_seq_t           i_seq,
   input  wire wcs_pkg::wcs_res_t           i_res,
   output logic [wcs_pkg::COUNT_W-1:0]      o_count,
   output logic                             o_limit_reached,
   output logic                             o_start_ok,
   output logic                             o_clear_prompt,
   output logic                             o_error_shown,
   output logic                             o_weld_fault,
   output logic                             o_cycle_done,
   output logic                             o_current_on
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic {CLR_IDLE, CLR_ASK} wcs_clr_st_t;
   typedef enum logic {DONE_OPEN, DONE_CLOSED} wcs_done_st_t;

   typedef struct packed {
      logic [wcs_pkg::COUNT_W-1:0]    count;
      logic                           limit_hit;
      wcs_clr_st_t                    clr_st;
      logic [wcs_pkg::CLR_TMR_W-1:0]  clr_tmr;
      logic                           bad_weld;
      logic                           press_bad;
      logic                           fault;
      logic                           hold_act;
      logic                           pause_act;
      logic                           err;
      wcs_done_st_t                   done_st;
      logic [wcs_pkg::DONE_TMR_W-1:0] done_tmr;
      logic                           off_act;
      logic                           cur_on;
      logic                           start_prev;
      logic                           clear_prev;
      logic                           conf_prev;
   } wcs_st_t;

   localparam logic [wcs_pkg::CLR_TMR_W-1:0]  CLR_LOAD  = wcs_pkg::CLR_TMR_W'(CLR_CYCLES - 1);
   localparam logic [wcs_pkg::DONE_TMR_W-1:0] DONE_LOAD = wcs_pkg::DONE_TMR_W'(DONE_CYCLES - 1);

   wcs_st_t                     st_q;
   wcs_st_t                     st_d;
   logic [wcs_pkg::PIN_W-1:0]   pins_raw;
   logic [wcs_pkg::PIN_W-1:0]   pins;
   logic                        start;
   logic                        run;
   logic                        clear_edge;
   logic                        conf_edge;
   logic                        start_fall;
   logic                        judged_bad;
   logic                        limit_on;
   logic                        msg_shown;

   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------
   assign pins_raw[wcs_pkg::PIN_START] = i_start_pin;
   assign pins_raw[wcs_pkg::PIN_CLEAR] = i_clear_key;
   assign pins_raw[wcs_pkg::PIN_CONF]  = i_confirm_key;
   assign pins_raw[wcs_pkg::PIN_FCLR]  = i_fault_clear;
   assign pins_raw[wcs_pkg::PIN_RUN]   = i_run_sel;

   wcs_sync #(
      .W (wcs_pkg::PIN_W)
   ) u_sync (
      .i_mclk   (i_mclk),
      .i_resetn (i_resetn),
      .i_async  (pins_raw),
      .o_sync   (pins)
   );

   assign start      = pins[wcs_pkg::PIN_START];
   assign run        = pins[wcs_pkg::PIN_RUN];
   assign clear_edge = pins[wcs_pkg::PIN_CLEAR] & ~st_q.clear_prev;
   assign conf_edge  = pins[wcs_pkg::PIN_CONF] & ~st_q.conf_prev;
   assign start_fall = ~start & st_q.start_prev;

   // ----------------------------------------------------------------
   // weld judgement
   // ----------------------------------------------------------------
   function automatic logic judge(input wcs_pkg::wcs_cfg_t c, input wcs_pkg::wcs_res_t r);
      logic cur_bad;
      logic ang_bad;
      logic lim_bad;
      logic qual_bad;
      logic mode_bad;
      cur_bad  = r.cur_lo | r.cur_hi;
      ang_bad  = r.ang_lo | r.ang_hi;
      case (c.limit_sel)
         wcs_pkg::LS_CURRENT: lim_bad = cur_bad;
         wcs_pkg::LS_ANGLE:   lim_bad = ang_bad;
         wcs_pkg::LS_BOTH:    lim_bad = cur_bad | ang_bad;
         default:             lim_bad = 1'b0;
      endcase
      case (c.quality_sel)
         wcs_pkg::QS_THICKNESS: qual_bad = r.thickness_check_lo | r.thickness_check_hi;
         wcs_pkg::QS_INDENT:    qual_bad = r.indent_lo | r.indent_hi;
         default:               qual_bad = 1'b0;
      endcase
      case (c.work_mode)
         wcs_pkg::WM_CONST_CURRENT: mode_bad = r.no_current;
         wcs_pkg::WM_CONST_ENERGY:  mode_bad = r.time_lo | r.time_hi
                                             | r.no_electrode_voltage
                                             | r.electrode_voltage_oos;
         default:                   mode_bad = 1'b0;
      endcase
      return lim_bad | qual_bad | mode_bad;
   endfunction

   assign judged_bad = judge(i_cfg, i_res);
   assign limit_on   = (i_cfg.weld_limit != wcs_pkg::COUNT_RST);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      st_d            = st_q;
      st_d.start_prev = start;
      st_d.clear_prev = pins[wcs_pkg::PIN_CLEAR];
      st_d.conf_prev  = pins[wcs_pkg::PIN_CONF];

      // counter and limit
      if (i_seq.weld_done && !i_cfg.dry_cycle)
      begin
         st_d.count = st_q.count + 1'b1;
      end

      // counter clear prompt; a clear key press first dismisses any error
      case (st_q.clr_st)
         CLR_IDLE:
         begin
            if (clear_edge && run && !st_q.err)
            begin
               st_d.clr_st  = CLR_ASK;
               st_d.clr_tmr = CLR_LOAD;
            end
         end
         CLR_ASK:
         begin
            if (!run)
            begin
               st_d.clr_st = CLR_IDLE;
            end
            else if (conf_edge)
            begin
               st_d.count  = wcs_pkg::COUNT_RST;
               st_d.clr_st = CLR_IDLE;
            end
            else if (st_q.clr_tmr == '0)
            begin
               st_d.clr_st = CLR_IDLE;
            end
            else
            begin
               st_d.clr_tmr = st_q.clr_tmr - 1'b1;
            end
         end
         default:
         begin
            st_d.clr_st = CLR_IDLE;
         end
      endcase

      // compare the settled count, so a count and a reset in one cycle agree
      st_d.limit_hit = limit_on && (st_d.count >= i_cfg.weld_limit);

      // judgement of the last weld
      if (i_res.valid)
      begin
         st_d.bad_weld = judged_bad;
      end

      // squeeze pressure is only checked with the pressure sensor fitted
      if (i_seq.squeeze && i_cfg.aux_input_select && i_res.press_out)
      begin
         st_d.press_bad = 1'b1;
      end

      // hold windows of the fault contact
      if (i_seq.hold_end)
      begin
         st_d.hold_act = 1'b0;
      end
      if (i_seq.pause_end)
      begin
         st_d.pause_act = 1'b0;
      end
      if (i_seq.hold_start && st_q.bad_weld)
      begin
         st_d.fault     = 1'b1;
         st_d.hold_act  = 1'b1;
         st_d.pause_act = i_cfg.pause_en;
         // a result arriving with hold start is kept for the next weld
         st_d.bad_weld  = i_res.valid & judged_bad;
      end

      // error display: clear first so a coincident new error still lands
      if ((clear_edge && st_q.err) || pins[wcs_pkg::PIN_FCLR])
      begin
         st_d.err = 1'b0;
      end
      if (i_seq.hold_start && st_q.bad_weld && i_cfg.stop_on_error)
      begin
         st_d.err = 1'b1;
      end
      if (start_fall && st_q.press_bad)
      begin
         st_d.err       = 1'b1;
         st_d.fault     = 1'b1;
         st_d.press_bad = i_seq.squeeze & i_cfg.aux_input_select & i_res.press_out;
      end

      // release once every holding reason is gone
      if (st_q.fault && !st_d.fault)
      begin
         st_d.fault = 1'b0;
      end
      else if (st_q.fault && !st_d.hold_act && !st_d.pause_act && !start && !st_d.err
               && !(i_seq.hold_start && st_q.bad_weld)
               && !(start_fall && st_q.press_bad))
      begin
         st_d.fault = 1'b0;
      end
      if (st_d.err)
      begin
         st_d.fault = 1'b1;
      end

      // cycle done contact
      if (i_seq.off_end)
      begin
         st_d.off_act = 1'b0;
      end
      case (st_q.done_st)
         DONE_OPEN:
         begin
            if (i_seq.hold_end)
            begin
               st_d.done_st  = DONE_CLOSED;
               st_d.done_tmr = DONE_LOAD;
               st_d.off_act  = i_cfg.off_time_en;
            end
         end
         DONE_CLOSED:
         begin
            // a new hold end restarts the contact, so it never opens on one
            if (i_seq.hold_end)
            begin
               st_d.off_act = i_cfg.off_time_en;
            end
            // the minimum time only runs once start has been let go
            if (start || i_seq.hold_end)
            begin
               st_d.done_tmr = DONE_LOAD;
            end
            else if (st_q.done_tmr != '0)
            begin
               st_d.done_tmr = st_q.done_tmr - 1'b1;
            end
            else if (!st_d.off_act && !msg_shown)
            begin
               st_d.done_st = DONE_OPEN;
            end
         end
         default:
         begin
            st_d.done_st = DONE_OPEN;
         end
      endcase

      // current-on follows every current interval of the sequencer
      st_d.cur_on = i_seq.current_active;
   end

   assign msg_shown = st_q.err | (st_q.clr_st == CLR_ASK) | st_q.limit_hit;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (!i_resetn)
      begin
         st_q         <= '0;
         st_q.clr_st  <= CLR_IDLE;
         st_q.done_st <= DONE_OPEN;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_count         = st_q.count;
   assign o_limit_reached = st_q.limit_hit;
   // refused before any valve or current is driven
   assign o_start_ok      = i_seq.start_req & ~st_q.limit_hit;
   assign o_clear_prompt  = (st_q.clr_st == CLR_ASK);
   assign o_error_shown   = st_q.err;
   assign o_weld_fault    = st_q.fault;
   assign o_cycle_done    = (st_q.done_st == DONE_CLOSED) ^ i_cfg.cascade_en;
   assign o_current_on    = st_q.cur_on;

endmodule

// file: verification/wcs_plant.sv
/*
 * Plant side model: counts closures of the cycle-done contact.
 * Assumes the contact is a level on i_mclk, cascade inversion off.
 */
module wcs_plant (
   input  wire logic i_mclk,
   input  wire logic i_done,
   output int        o_done_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic done_q = 1'h0;
   int   cnt_q  = 0;
   assign o_done_cnt = cnt_q;
   // a plant input reacts to contact edges only
   always @(posedge i_mclk)
   begin
      done_q <= i_done;
      if (i_done && !done_q)
         cnt_q <= cnt_q + 1;
   end
endmodule

// file: verification/wcs_top_assertions.sv
/*
 * Port checks of wcs_top, bound into every instance.
 * Assumes weld_limit changes only while reset is held.
 */
module wcs_top_assertions #(
   parameter int CLR_CYCLES  = 50,
   parameter int DONE_CYCLES = 20
) (
   input wire logic                   i_mclk,
   input wire logic                   i_resetn,
   input wire wcs_pkg::wcs_cfg_t      i_cfg,
   input wire wcs_pkg::wcs_seq_t      i_seq,
   input wire logic [16:0]            o_count,
   input wire logic                   o_limit_reached,
   input wire logic                   o_start_ok,
   input wire logic                   o_clear_prompt,
   input wire logic                   o_error_shown,
   input wire logic                   o_weld_fault,
   input wire logic                   o_cycle_done,
   input wire logic                   o_current_on
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   // ------
   // helpers
   // ------
   logic done_lvl;
   int   prompt_n;
   int   done_n;
   // cascade only flips the contact, so judge the level behind it
   assign done_lvl = o_cycle_done ^ i_cfg.cascade_en;
   always_ff @(posedge i_mclk)
   begin
      prompt_n <= (i_resetn && o_clear_prompt) ? prompt_n + 1 : 0;
      done_n   <= (i_resetn && done_lvl) ? done_n + 1 : 0;
   end
   sequence s_weld;
      i_seq.weld_done && !i_cfg.dry_cycle && !o_clear_prompt;
   endsequence
   sequence s_dry;
      i_seq.weld_done && i_cfg.dry_cycle && !o_clear_prompt;
   endsequence
   sequence s_cur_run;
      i_seq.current_active [*2];
   endsequence
   sequence s_cur_idle;
      (!i_seq.current_active) [*2];
   endsequence
   // ------
   // checks
   // ------
   AST_COUNT_UP: assert property (s_weld |=> o_count == $past(o_count) + 17'h00001)
      else $error("count did not step");
   AST_DRY_KEEP: assert property (s_dry |=> $stable(o_count))
      else $error("dry cycle counted");
   AST_LIMIT_CMP: assert property ($stable(i_cfg.weld_limit) && i_cfg.weld_limit != 17'h00000
      |-> o_limit_reached == (o_count >= i_cfg.weld_limit)) else $error("limit flag wrong");
   AST_LIMIT_OFF: assert property (i_cfg.weld_limit == 17'h00000 |-> !o_limit_reached)
      else $error("limit with zero limit");
   AST_START_GATE: assert property (o_start_ok == (i_seq.start_req && !o_limit_reached))
      else $error("start gate wrong");
   AST_PROMPT_MAX: assert property (o_clear_prompt |-> prompt_n <= CLR_CYCLES + 1)
      else $error("prompt too long");
   AST_FAULT_CAUSE: assert property ($rose(o_weld_fault) |-> $past(i_seq.hold_start) || o_error_shown)
      else $error("fault without cause");
   AST_FAULT_ERR: assert property (o_error_shown |-> o_weld_fault)
      else $error("error without fault");
   AST_FAULT_FREE: assert property ($fell(o_weld_fault) |-> !o_error_shown)
      else $error("fault freed with error");
   AST_DONE_SET: assert property (i_seq.hold_end |=> done_lvl)
      else $error("cycle done not closed");
   AST_DONE_MIN: assert property ($fell(done_lvl) |-> done_n >= DONE_CYCLES)
      else $error("cycle done too short");
   AST_CUR_ON: assert property (s_cur_run |-> o_current_on)
      else $error("current contact open");
   AST_CUR_OFF: assert property (s_cur_idle |-> !o_current_on)
      else $error("current contact closed");
endmodule

bind wcs_top wcs_top_assertions #(.CLR_CYCLES(CLR_CYCLES), .DONE_CYCLES(DONE_CYCLES)) i_chk (
   .i_mclk(i_mclk), .i_resetn(i_resetn), .i_cfg(i_cfg), .i_seq(i_seq), .o_count(o_count),
   .o_limit_reached(o_limit_reached), .o_start_ok(o_start_ok), .o_clear_prompt(o_clear_prompt),
   .o_error_shown(o_error_shown), .o_weld_fault(o_weld_fault), .o_cycle_done(o_cycle_done),
   .o_current_on(o_current_on));

// file: verification/wcs_top_test.sv
/*
 * Self-checking bench of wcs_top with a plant model on cycle-done.
 * Assumes short clear and cycle-done counts; sequencer events by hand.
 */
module wcs_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ------
   // bench
   // ------
   localparam int          CLR_N  = 50;
   localparam int          DONE_N = 20;
   localparam logic [7:0]  HS     = 8'h20;
   localparam logic [7:0]  HE     = 8'h10;
   localparam logic [7:0]  PE     = 8'h08;
   localparam logic [7:0]  OE     = 8'h04;
   localparam logic [7:0]  WD     = 8'h02;
   // mode, limit select, quality select, result bit, fault expected
   localparam logic [19:0] CASES [18] = '{20'h000D0, 20'h010C1, 20'h010B0, 20'h020A1, 20'h030D1,
      20'h00090, 20'h00080, 20'h10091, 20'h100D0, 20'h120B1, 20'h20081, 20'h20071, 20'h20061,
      20'h20051, 20'h210C1, 20'h00131, 20'h00221, 20'h00240};
   logic              mclk   = 1'h0;
   logic              resetn = 1'h0;
   logic              start  = 1'h0;
   logic              clr    = 1'h0;
   logic              conf   = 1'h0;
   logic              fclr   = 1'h0;
   logic              run    = 1'h1;
   wcs_pkg::wcs_cfg_t cfg    = '0;
   wcs_pkg::wcs_seq_t seq    = '0;
   wcs_pkg::wcs_res_t res    = '0;
   logic [16:0]       count;
   logic              lim, ok, prompt, err, fault, done, cur;
   int                done_cnt;
   int                err_count = 0;
   int                checked   = 0;
   int                cyc       = 0;

   wcs_top #(.CLR_CYCLES(CLR_N), .DONE_CYCLES(DONE_N)) i_dut (.i_mclk(mclk), .i_resetn(resetn),
      .i_start_pin(start), .i_clear_key(clr), .i_confirm_key(conf), .i_fault_clear(fclr),
      .i_run_sel(run), .i_cfg(cfg), .i_seq(seq), .i_res(res), .o_count(count), .o_limit_reached(lim),
      .o_start_ok(ok), .o_clear_prompt(prompt), .o_error_shown(err), .o_weld_fault(fault),
      .o_cycle_done(done), .o_current_on(cur));
   wcs_plant i_plant (.i_mclk(mclk), .i_done(done), .o_done_cnt(done_cnt));

   always #50 mclk = ~mclk;
   // the run needs well under 3000 cycles
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop;
      if (err_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic tick(input int n = 1);
      repeat (n)
      begin
         @(posedge mclk);
         #5;
      end
   endtask
   task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic pulse(input logic [7:0] m);
      seq = seq | m;
      tick();
      seq = seq & ~m;
   endtask
   task automatic do_reset;
      resetn = 1'h0;
      tick(4);
      resetn = 1'h1;
      tick(3);
   endtask
   task automatic key(ref logic k);
      k = 1'h1;
      tick(4);
      k = 1'h0;
      tick(2);
   endtask
   task automatic bad_weld(input logic [3:0] b);
      res = '0;
      res[b] = 1'h1;
      res.valid = 1'h1;
      tick();
      res = '0;
      pulse(HS);
      tick();
   endtask

   // ------
   // scenarios
   // ------
   task automatic t_count;
      do_reset();
      pulse(WD | WD);
      seq.weld_done = 1'h1;
      tick(2);
      seq.weld_done = 1'h0;
      check("count", count, 17'h00003);
      cfg.dry_cycle = 1'h1;
      pulse(WD);
      cfg.dry_cycle = 1'h0;
      check("count_dry", count, 17'h00003);
      check("limit_zero", lim, 17'h00000);
   endtask
   task automatic t_limit;
      cfg.weld_limit = 17'h00002;
      do_reset();
      pulse(WD);
      check("limit_early", lim, 17'h00000);
      pulse(WD);
      seq.start_req = 1'h1;
      tick();
      check("limit", lim, 17'h00001);
      check("start_ok", ok, 17'h00000);
      seq.start_req = 1'h0;
      run = 1'h0;
      key(clr);
      check("prompt_prog", prompt, 17'h00000);
      run = 1'h1;
      tick(3);
      key(clr);
      check("prompt", prompt, 17'h00001);
      key(conf);
      check("count_clr", count, 17'h00000);
      check("limit_clr", lim, 17'h00000);
      cfg.weld_limit = 17'h00000;
   endtask
   task automatic t_timeout;
      do_reset();
      pulse(WD);
      key(clr);
      tick(CLR_N - 10);
      check("prompt_wait", prompt, 17'h00001);
      tick(20);
      check("prompt_gone", prompt, 17'h00000);
      key(conf);
      check("count_kept", count, 17'h00001);
   endtask
   task automatic t_fault_table;
      logic [19:0] c;
      foreach (CASES[i])
      begin
         c = CASES[i];
         cfg.work_mode   = wcs_pkg::wcs_work_mode_t'(c[17:16]);
         cfg.limit_sel   = wcs_pkg::wcs_limit_sel_t'(c[13:12]);
         cfg.quality_sel = wcs_pkg::wcs_quality_sel_t'(c[9:8]);
         bad_weld(c[7:4]);
         check("fault", fault, {16'h0000, c[0]});
         pulse(HE);
         tick(3);
         check("fault_rel", fault, 17'h00000);
      end
   endtask
   task automatic t_hold;
      cfg.pause_en = 1'h1;
      cfg.quality_sel = wcs_pkg::QS_THICKNESS;
      start = 1'h1;
      tick(3);
      bad_weld(4'h3);
      pulse(HE);
      tick(3);
      check("fault_start", fault, 17'h00001);
      start = 1'h0;
      tick(5);
      check("fault_pause", fault, 17'h00001);
      pulse(PE);
      tick(2);
      check("fault_free", fault, 17'h00000);
      cfg.pause_en = 1'h0;
   endtask
   task automatic t_error;
      cfg.stop_on_error = 1'h1;
      for (int k = 0; k < 2; k++)
      begin
         bad_weld(4'h3);
         pulse(HE);
         tick(8);
         check("error", err, 17'h00001);
         check("fault_err", fault, 17'h00001);
         if (k == 0)
            key(fclr);
         else
            key(clr);
         tick();
         check("error_clr", err, 17'h00000);
         check("fault_clr", fault, 17'h00000);
      end
      cfg.stop_on_error = 1'h0;
   endtask
   task automatic t_press;
      cfg.aux_input_select = 1'h1;
      start = 1'h1;
      seq.squeeze = 1'h1;
      tick(3);
      res.press_out = 1'h1;
      tick();
      res.press_out = 1'h0;
      seq.squeeze = 1'h0;
      tick();
      check("press_early", fault, 17'h00000);
      start = 1'h0;
      tick(5);
      check("press_err", err, 17'h00001);
      check("press_fault", fault, 17'h00001);
      key(fclr);
      cfg.aux_input_select = 1'h0;
   endtask
   task automatic t_done;
      int n0;
      tick(DONE_N + 5);
      n0 = done_cnt;
      start = 1'h1;
      tick(3);
      pulse(HE);
      tick();
      check("done", done, 17'h00001);
      check("plant_done", done_cnt[16:0], n0[16:0] + 17'h00001);
      tick(DONE_N + 10);
      check("done_start", done, 17'h00001);
      start = 1'h0;
      tick(DONE_N / 2);
      check("done_min", done, 17'h00001);
      tick(DONE_N + 5);
      check("done_end", done, 17'h00000);
      cfg.off_time_en = 1'h1;
      pulse(HE);
      tick(DONE_N + 10);
      check("done_off", done, 17'h00001);
      pulse(OE);
      tick(3);
      check("done_off_end", done, 17'h00000);
      cfg.off_time_en = 1'h0;
      cfg.cascade_en = 1'h1;
      tick();
      check("cascade_idle", done, 17'h00001);
      pulse(HE);
      tick();
      check("cascade_act", done, 17'h00000);
      tick(DONE_N + 5);
      cfg.cascade_en = 1'h0;
   endtask
   task automatic t_cur;
      seq.current_active = 1'h1;
      tick(2);
      check("cur_on", cur, 17'h00001);
      tick(5);
      check("cur_hold", cur, 17'h00001);
      seq.current_active = 1'h0;
      tick(2);
      check("cur_off", cur, 17'h00000);
   endtask

   initial
   begin
      t_count();
      t_limit();
      t_timeout();
      t_fault_table();
      t_hold();
      t_error();
      t_press();
      t_done();
      t_cur();
      report_and_stop();
   end
endmodule
